// file: logic/mpo_top.sv
// top: monitor pulse output generator with axi4-lite register slave
// Notes on behaviour
// R1: source code picks frequency, current, torque, fm, voltage, power, thermal, ramp; default 00
// R2: torque selection meaningful only in sensorless, zero-hertz sensorless or vector control
// R3: gain 0..255, default 60, writable during run in both modes
// R4: source writes during run accepted only in extended mode, rejected otherwise
// R5: all non-fm selections give a constant-period square wave
// R6: pwm high width proportional to selected value
// R7: code 03 switches output to frequency modulation
// R8: fm frequency tracks output frequency with about 50 % duty
// R9: fm frequency ten times output frequency, 4 kHz at full scale
// R10: fm output produced digitally, without matching or gain
// R11: pwm width scaled by gain, saturating at full-period high
`timescale 1ns/1ps
module mpo_top
  import mpo_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // drive state
  input  wire logic        i_running,
  input  wire logic        i_extended_mode,
  input  wire logic [1:0]  i_ctl_mode,
  // monitored quantities, 16-bit full scale
  input  wire logic [15:0] i_freq,
  input  wire logic [15:0] i_current,
  input  wire logic [15:0] i_torque,
  input  wire logic [15:0] i_voltage,
  input  wire logic [15:0] i_power,
  input  wire logic [15:0] i_thermal,
  input  wire logic [15:0] i_ramp,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // pulse output
  output logic             o_pulse
);
  localparam int CW = $clog2(MPO_PWM_PERIOD_CYC);
  localparam logic [CW-1:0] PER_LAST = CW'(MPO_PWM_PERIOD_CYC - 1);

  logic [7:0]    src_reg;
  logic [7:0]    gain_reg;
  logic          rej_reg;
  logic          aw_got_reg;
  logic          w_got_reg;
  logic [7:0]    awaddr_reg;
  logic [31:0]   wdata_reg;
  logic [3:0]    wstrb_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] thr_reg;
  logic [CW-1:0] thr_next;
  logic          pulse_reg;
  logic          fm_wave;
  logic          fm_mode;
  logic          torque_ok;
  logic [15:0]   sel_val;
  logic          wr_fire;
  logic          run_s1_reg;
  logic          run_s2_reg;
  logic          ext_s1_reg;
  logic          ext_s2_reg;
  logic [39:0]   scaled;

  // running and extended-mode pins come from another domain: two flops each; the control mode is used directly
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      run_s1_reg <= 1'b0;
      run_s2_reg <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
    end
    else
    begin
      run_s1_reg <= i_running;
      run_s2_reg <= run_s1_reg;
      ext_s1_reg <= i_extended_mode;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  // write channel capture; address and data taken in either order
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end
    else if (wr_fire)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  assign wr_fire       = aw_got_reg && w_got_reg && !s_axi_bvalid;

  // ready flags come from flops: they drop on the handshake and return only once the
  // response has been taken, so a second write can never overtake the pending one
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awready <= 1'b0;
      else if (!aw_got_reg && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wready <= 1'b0;
      else if (!w_got_reg && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
    end
  end

  // register writes and write response
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      src_reg      <= MPO_SRC_RST; // R1
      gain_reg     <= MPO_GAIN_RST; // R3
      rej_reg      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= MPO_RESP_OKAY;
    end
    else
    begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= MPO_RESP_OKAY;
        case (awaddr_reg)
          MPO_OFS_SRC:
          begin
            // locked while running unless extended mode is active
            if (run_s2_reg && !ext_s2_reg)
            begin
              rej_reg     <= 1'b1; // R4
              s_axi_bresp <= MPO_RESP_SLVERR; // R4
            end
            else if (wstrb_reg[0])
              src_reg <= {5'b00000, wdata_reg[2:0]}; // R1
          end
          MPO_OFS_GAIN:
            if (wstrb_reg[0])
              gain_reg <= wdata_reg[7:0]; // R3
          MPO_OFS_STATUS:
            // write one clears the sticky reject flag
            if (wstrb_reg[0] && wdata_reg[MPO_ST_REJ_BIT])
              rej_reg <= 1'b0;
          default:
            s_axi_bresp <= MPO_RESP_SLVERR;
        endcase
      end
    end
  end

  // read channel: one read at a time, answer one cycle after address
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= MPO_RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= MPO_RESP_OKAY;
      case (s_axi_araddr)
        MPO_OFS_SRC:    s_axi_rdata <= {24'h00_0000, src_reg};
        MPO_OFS_GAIN:   s_axi_rdata <= {24'h00_0000, gain_reg};
        MPO_OFS_STATUS: s_axi_rdata <= {28'h000_0000, pulse_reg, torque_ok, fm_mode, rej_reg};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= MPO_RESP_SLVERR;
        end
      endcase
    end
  end

  // read address ready from a flop; it returns one cycle after the read data are taken
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      s_axi_arready <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready)
      s_axi_arready <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // torque has meaning only under the vector control modes
  assign torque_ok = (i_ctl_mode != MPO_CTL_VF); // R2
  assign fm_mode   = (src_reg[2:0] == MPO_SRC_FREQ_FM); // R7

  // source selection
  always_comb
  begin
    case (mpo_src_e'(src_reg[2:0]))
      MPO_SRC_FREQ_PWM: sel_val = i_freq; // R1
      MPO_SRC_CURRENT:  sel_val = i_current;
      MPO_SRC_TORQUE:   sel_val = torque_ok ? i_torque : 16'h0000; // R2
      MPO_SRC_VOLTAGE:  sel_val = i_voltage;
      MPO_SRC_POWER:    sel_val = i_power;
      MPO_SRC_THERMAL:  sel_val = i_thermal;
      MPO_SRC_RAMP:     sel_val = i_ramp;
      default:          sel_val = 16'h0000;
    endcase
  end

  // width = value * period * gain / (65536 * unity), saturated to full period
  assign scaled = 40'(({24'h00_0000, sel_val} * 40'(MPO_PWM_PERIOD_CYC) * {32'h0, gain_reg})
                  / (40'h00_0001_0000 * {32'h0, MPO_GAIN_UNITY})); // R6 R11
  assign thr_next = (scaled > 40'(MPO_PWM_PERIOD_CYC)) ? CW'(MPO_PWM_PERIOD_CYC)
                                                       : CW'(scaled); // R11

  // fixed-period counter; threshold latched at period start to avoid glitches
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_reg <= '0;
      thr_reg <= '0;
    end
    else if (cnt_reg == PER_LAST)
    begin
      cnt_reg <= '0; // R5
      thr_reg <= thr_next;
    end
    else
      cnt_reg <= cnt_reg + CW'(1);
  end

  mpo_fm_gen u_fm
  (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_run  (fm_mode),
    .i_freq (i_freq),
    .o_wave (fm_wave)
  );

  // output mux, registered
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      pulse_reg <= 1'b0;
    else if (fm_mode)
      pulse_reg <= fm_wave; // R7 R10
    else
      pulse_reg <= (cnt_reg < thr_reg); // R6 R11
  end

  assign o_pulse = pulse_reg;

  chk_src_locked: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    (wr_fire && awaddr_reg == MPO_OFS_SRC && run_s2_reg && !ext_s2_reg)
    |=> $stable(src_reg) && rej_reg)
    else $error("source changed while locked");
  chk_gain_run: assert property (@(posedge i_clk) disable iff (i_rst) // R3
    (wr_fire && awaddr_reg == MPO_OFS_GAIN && wstrb_reg[0]) |=> gain_reg == $past(wdata_reg[7:0]))
    else $error("gain write lost");
  chk_period_wrap: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    cnt_reg == PER_LAST |=> cnt_reg == '0)
    else $error("pwm period wrong");
  chk_pwm_sat: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    thr_reg <= CW'(MPO_PWM_PERIOD_CYC))
    else $error("threshold above period");
  chk_pwm_out: assert property (@(posedge i_clk) disable iff (i_rst) // R6
    (!fm_mode && cnt_reg == '0 && thr_reg != '0) |=> pulse_reg)
    else $error("pwm not high at period start");
  chk_fm_follow: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    fm_mode |=> pulse_reg == $past(fm_wave))
    else $error("fm wave not routed");
  chk_torque_gate: assert property (@(posedge i_clk) disable iff (i_rst) // R2
    (src_reg[2:0] == MPO_SRC_TORQUE && !torque_ok) |-> sel_val == 16'h0000)
    else $error("torque passed outside vector modes");
  chk_wr_resp: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    wr_fire |=> s_axi_bvalid)
    else $error("no write response");
  cov_fm: cover property (@(posedge i_clk) disable iff (i_rst) fm_mode && $rose(pulse_reg));
  cov_rej: cover property (@(posedge i_clk) disable iff (i_rst) $rose(rej_reg));
  cov_full: cover property (@(posedge i_clk) disable iff (i_rst) thr_reg == CW'(MPO_PWM_PERIOD_CYC));
endmodule // mpo_top

// file: inc/mpo_pkg.sv
// package: register map, codes and timing constants for the monitor pulse output
package mpo_pkg;
  // register byte offsets (aligned words on the axi4-lite slave)
  localparam logic [7:0] MPO_OFS_SRC     = 8'h00;
  localparam logic [7:0] MPO_OFS_GAIN    = 8'h04;
  localparam logic [7:0] MPO_OFS_STATUS  = 8'h08;
  // reset values
  localparam logic [7:0] MPO_SRC_RST     = 8'h00;
  localparam logic [7:0] MPO_GAIN_RST    = 8'h3c;
  // gain of 0x3c (60) is unity scale
  localparam logic [7:0] MPO_GAIN_UNITY  = 8'h3c;
  // status field positions
  localparam int MPO_ST_REJ_BIT  = 0;
  localparam int MPO_ST_FM_BIT   = 1;
  localparam int MPO_ST_TQV_BIT  = 2;
  localparam int MPO_ST_OUT_BIT  = 3;
  // axi responses
  localparam logic [1:0] MPO_RESP_OKAY   = 2'b00;
  localparam logic [1:0] MPO_RESP_SLVERR = 2'b10;
  // source selection codes
  typedef enum logic [2:0] {
    MPO_SRC_FREQ_PWM = 3'b000,
    MPO_SRC_CURRENT  = 3'b001,
    MPO_SRC_TORQUE   = 3'b010,
    MPO_SRC_FREQ_FM  = 3'b011,
    MPO_SRC_VOLTAGE  = 3'b100,
    MPO_SRC_POWER    = 3'b101,
    MPO_SRC_THERMAL  = 3'b110,
    MPO_SRC_RAMP     = 3'b111
  } mpo_src_e;
  // control modes; torque is meaningful only for the vector modes
  typedef enum logic [1:0] {
    MPO_CTL_VF       = 2'b00,
    MPO_CTL_SLV      = 2'b01,
    MPO_CTL_SLV_0HZ  = 2'b10,
    MPO_CTL_VECTOR   = 2'b11
  } mpo_ctl_e;
  // timing: pwm period and fm full-scale frequency
  localparam int MPO_CLK_HZ       = 200_000_000;
  localparam int MPO_PWM_PERIOD_US = 25; // short period keeps a meter reading within a few periods
  localparam int MPO_PWM_PERIOD_CYC = MPO_CLK_HZ / 1_000_000 * MPO_PWM_PERIOD_US;
  localparam int MPO_FM_MAX_HZ    = 4000;
  // fm phase accumulator: full-scale 16-bit input gives MPO_FM_MAX_HZ
  localparam int MPO_ACC_W        = 32;
  localparam longint MPO_FM_STEP_FS =
    (64'd1 << MPO_ACC_W) * MPO_FM_MAX_HZ / MPO_CLK_HZ;
endpackage : mpo_pkg

// file: logic/mpo_fm_gen.sv
// fm generator: square wave whose frequency tracks the output frequency
`timescale 1ns/1ps
module mpo_fm_gen
  import mpo_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // control
  input  wire logic        i_run,
  input  wire logic [15:0] i_freq,
  // output
  output logic             o_wave
);
  logic [MPO_ACC_W-1:0] acc_reg;
  logic [MPO_ACC_W-1:0] step;

  // step scales the frequency word; no gain or matching is applied here
  assign step = MPO_ACC_W'((longint'(i_freq) * MPO_FM_STEP_FS) >> 16); // R10

  // phase accumulator; msb gives a square wave of about 50 % duty
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_run)
      acc_reg <= '0;
    else
      acc_reg <= acc_reg + step; // R8 R9
  end

  assign o_wave = acc_reg[MPO_ACC_W-1];
endmodule // mpo_fm_gen

// file: dv/mpo_meter.sv
// partner model: frequency meter timing the monitor pulse between rising edges
`timescale 1ns/1ps
module mpo_meter
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // measured line
  input  wire logic        i_pulse,
  // last full period, its high time and a count of rising edges
  output logic [31:0]      o_period,
  output logic [31:0]      o_high,
  output logic [7:0]       o_edges
);
  logic        prev_reg;
  logic [31:0] per_cnt_reg;
  logic [31:0] high_cnt_reg;
  // a period is only valid between two rising edges, so the bench waits for two new ones
  always_ff @(posedge i_clk)
  begin
    prev_reg <= i_pulse;
    if (i_rst)
    begin
      per_cnt_reg  <= 32'h0;
      high_cnt_reg <= 32'h0;
      o_period     <= 32'h0;
      o_high       <= 32'h0;
      o_edges      <= 8'h0;
    end
    else if (i_pulse && !prev_reg)
    begin
      o_period     <= per_cnt_reg;
      o_high       <= high_cnt_reg;
      o_edges      <= o_edges + 8'h1;
      per_cnt_reg  <= 32'h1;
      high_cnt_reg <= 32'h1;
    end
    else
    begin
      per_cnt_reg  <= per_cnt_reg + 32'h1;
      high_cnt_reg <= high_cnt_reg + {31'h0, i_pulse};
    end
  end
endmodule // mpo_meter

// file: dv/mpo_top_tb_top.sv
// testbench: register access, run-mode locking and fm timing of the pulse output
`timescale 1ns/1ps
module mpo_top_tb_top
  import mpo_pkg::*;
();
  logic        i_clk, i_rst, i_running, i_extended_mode, o_pulse;
  logic [1:0]  i_ctl_mode, s_axi_bresp, s_axi_rresp;
  logic [15:0] i_freq, i_current, i_torque, i_voltage, i_power, i_thermal, i_ramp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, m_edges, e0, g;
  logic [31:0] s_axi_wdata, s_axi_rdata, m_period, m_high, per;
  logic [3:0]  s_axi_wstrb;
  int          num_errors, checks_done;

  mpo_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_running(i_running),
    .i_extended_mode(i_extended_mode), .i_ctl_mode(i_ctl_mode), .i_freq(i_freq),
    .i_current(i_current), .i_torque(i_torque), .i_voltage(i_voltage), .i_power(i_power),
    .i_thermal(i_thermal), .i_ramp(i_ramp), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .o_pulse(o_pulse));
  mpo_meter i_meter (.i_clk(i_clk), .i_rst(i_rst), .i_pulse(o_pulse), .o_period(m_period),
    .o_high(m_high), .o_edges(m_edges));

  // compare with an optional tolerance for measured times
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
    checks_done++;
    if ($isunknown(got) || (got !== exp && (tol == 0 || got > exp + tol || got + tol < exp)))
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, response awaited without a fixed latency
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge i_clk);
  endtask
  // read and compare the masked data and the response
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed,
                        input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata & m, ed);
    check({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge i_clk);
  endtask
  // one status bit in place
  function automatic logic [31:0] sbit(input int pos, input bit v);
    return 32'(v) << pos;
  endfunction
  // expected fm period in clocks: full-scale input gives the top frequency
  function automatic logic [31:0] fm_per(input logic [15:0] f);
    return 32'(64'(MPO_CLK_HZ) * 64'd65536 / (64'(f) * 64'(MPO_FM_MAX_HZ)));
  endfunction
  // expected pwm high time: share of full scale times period, scaled by gain over unity
  function automatic logic [31:0] pwm_high(input logic [15:0] v, input logic [7:0] gn);
    longint h;
    h = longint'(v) * MPO_PWM_PERIOD_CYC * longint'(gn) / (65536 * longint'(MPO_GAIN_UNITY));
    return (h > MPO_PWM_PERIOD_CYC) ? 32'(MPO_PWM_PERIOD_CYC) : 32'(h);
  endfunction
  task automatic settle();
    repeat (4) @(posedge i_clk);
  endtask
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // hang guard: fm needs about 75000 cycles, the pwm reading about two of its periods
  initial
  begin
    repeat (100000) @(posedge i_clk);
    num_errors++;
    $display("BAD t=%0t timeout", $time);
    print_verdict();
  end

  initial
  begin
    void'($urandom(32'h00b6));
    {i_running, i_extended_mode, i_ctl_mode, i_rst} = 5'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {i_freq, i_current, i_torque, i_voltage} = {$urandom, $urandom};
    {i_power, i_thermal, i_ramp} = 48'({$urandom, $urandom});
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    axi_rd(MPO_OFS_SRC, 32'hffff_ffff, 32'h0, MPO_RESP_OKAY);
    axi_rd(MPO_OFS_GAIN, 32'hffff_ffff, 32'h3c, MPO_RESP_OKAY);
    // torque flag per control mode, ending in v/f so the torque source is gated later
    for (int m = 3; m >= 0; m--)
    begin
      i_ctl_mode <= 2'(m);
      settle();
      axi_rd(MPO_OFS_STATUS, sbit(MPO_ST_TQV_BIT, 1), sbit(MPO_ST_TQV_BIT, m != 0),
             MPO_RESP_OKAY);
    end
    // every source code while stopped, random junk in unused bits 7:3
    for (int c = 0; c < 8; c++)
    begin
      axi_wr(MPO_OFS_SRC, ($urandom & 32'hf8) | 32'(c), MPO_RESP_OKAY);
      axi_rd(MPO_OFS_SRC, 32'hffff_ffff, 32'(c), MPO_RESP_OKAY);
      axi_rd(MPO_OFS_STATUS, sbit(MPO_ST_FM_BIT, 1), sbit(MPO_ST_FM_BIT, c == 3),
             MPO_RESP_OKAY);
    end
    // pwm on the ramp source: exact period and gain-scaled high time, kept clear of both ends
    g = 8'h20 + 8'($urandom % 64);
    i_ramp <= 16'h1000 + 16'($urandom & 32'h7fff);
    axi_wr(MPO_OFS_GAIN, {24'h0, g}, MPO_RESP_OKAY);
    settle();
    e0 = m_edges;
    while (8'(m_edges - e0) < 8'd2)
      @(posedge i_clk);
    check(m_period, 32'(MPO_PWM_PERIOD_CYC));
    check(m_high, pwm_high(i_ramp, g));
    // gain while running in normal mode, both ends of its range first
    i_running <= 1'b1;
    settle();
    for (int k = 0; k < 4; k++)
    begin
      g = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      axi_wr(MPO_OFS_GAIN, {24'h0, g}, MPO_RESP_OKAY);
      axi_rd(MPO_OFS_GAIN, 32'hffff_ffff, {24'h0, g}, MPO_RESP_OKAY);
    end
    // source locked while running in normal mode; sticky flag cleared by writing one
    axi_wr(MPO_OFS_SRC, 32'h5, MPO_RESP_SLVERR);
    axi_rd(MPO_OFS_SRC, 32'hffff_ffff, 32'h7, MPO_RESP_OKAY);
    axi_rd(MPO_OFS_STATUS, 32'h1, 32'h1, MPO_RESP_OKAY);
    axi_wr(MPO_OFS_STATUS, 32'h1, MPO_RESP_OKAY);
    axi_rd(MPO_OFS_STATUS, 32'h1, 32'h0, MPO_RESP_OKAY);
    // unmapped word
    axi_rd(8'h0c, 32'hffff_ffff, 32'h0, MPO_RESP_SLVERR);
    axi_wr(8'h0c, 32'h1, MPO_RESP_SLVERR);
    // extended mode unlocks the source; fm at full scale with gain zero
    i_extended_mode <= 1'b1;
    i_freq          <= 16'hffff;
    settle();
    axi_wr(MPO_OFS_GAIN, 32'h0, MPO_RESP_OKAY);
    axi_wr(MPO_OFS_SRC, 32'h3, MPO_RESP_OKAY);
    axi_rd(MPO_OFS_SRC, 32'hffff_ffff, 32'h3, MPO_RESP_OKAY);
    e0 = m_edges;
    while (8'(m_edges - e0) < 8'd2)
      @(posedge i_clk);
    per = fm_per(16'hffff);
    check(m_period, per, int'(per / 32));
    check(m_high, per / 2, int'(per / 32));
    print_verdict();
  end
endmodule // mpo_top_tb_top
